//--- verilog/pte_pkg.sv
package pte_pkg;
	// register byte offsets on the plain register port
	localparam logic [7:0] OFF_MSR = 8'h00;
	localparam logic [7:0] OFF_ESR = 8'h04;
	localparam logic [7:0] OFF_EAR = 8'h08;
	localparam logic [7:0] OFF_FSR = 8'h0C;
	localparam logic [7:0] OFF_BTR = 8'h10;
	localparam logic [7:0] OFF_STK_LO = 8'h14;
	localparam logic [7:0] OFF_STK_HI = 8'h18;
	// machine status register bit positions
	localparam int MSR_IE = 1;
	localparam int MSR_BIP = 3;
	localparam int MSR_EE = 8;
	localparam int MSR_EIP = 9;
	localparam int MSR_UM = 11;
	localparam int MSR_UMS = 12;
	localparam int MSR_VM = 13;
	localparam int MSR_VMS = 14;
	localparam logic [31:0] MSR_RESET = 32'h0000_0000;
	// exception status register fields
	localparam int ESR_DS = 12;
	localparam logic [4:0] EC_IBUS = 5'h03;
	localparam logic [4:0] EC_ILLEGAL = 5'h02;
	localparam logic [4:0] EC_DBUS = 5'h04;
	localparam logic [4:0] EC_UNALIGN = 5'h01;
	localparam logic [4:0] EC_DIV = 5'h05;
	localparam logic [4:0] EC_FPU = 5'h06;
	localparam logic [4:0] EC_PRIV = 5'h07;
	localparam logic [4:0] EC_STACK = 5'h07;
	localparam logic [4:0] EC_DSTORE = 5'h10;
	localparam logic [4:0] EC_ISTORE = 5'h11;
	localparam logic [4:0] EC_DTLB = 5'h12;
	localparam logic [4:0] EC_ITLB = 5'h13;
	// float status register flag positions
	localparam int FSR_DO = 0;
	localparam int FSR_UF = 1;
	localparam int FSR_OF = 2;
	localparam int FSR_DZ = 3;
	localparam int FSR_IO = 4;
	// vector offsets and return-address register indices
	localparam logic [31:0] VEC_IRQ = 32'h0000_0010;
	localparam logic [31:0] VEC_BRK = 32'h0000_0018;
	localparam logic [31:0] VEC_EXC = 32'h0000_0020;
	localparam logic [4:0] GPR_IRQ = 5'h0E;
	localparam logic [4:0] GPR_BRK = 5'h10;
	localparam logic [4:0] GPR_EXC = 5'h11;
	// interrupt acknowledge codes
	localparam logic [1:0] ACK_NONE = 2'h0;
	localparam logic [1:0] ACK_ENTRY = 2'h1;
	localparam logic [1:0] ACK_RETURN = 2'h2;
	localparam logic [1:0] ACK_REENABLE = 2'h3;
	typedef enum logic [1:0] {ST_RUN = 2'b01, ST_HALT = 2'b10} pte_state_t;
	typedef struct packed {
		pte_state_t state;
		logic [31:0] machine_status_reg;
		logic [31:0] exception_status_reg;
		logic [31:0] exception_address_reg;
		logic [31:0] float_status_reg;
		logic [31:0] branch_target_reg;
		logic [31:0] stk_lo;
		logic [31:0] stk_hi;
		logic irq_prev;
		logic irq_pend;
		logic [1:0] ack;
		logic [31:0] rdata;
		logic redir;
		logic [31:0] redir_pc;
		logic gpr_we;
		logic [4:0] gpr_idx;
		logic [31:0] gpr_data;
		logic resv_clr;
		logic flush;
		logic sw_bkpt;
	} pte_regs_t;
endpackage

//--- verilog/pte_trap_entry.sv
// Chosen here: the plain strobed port and the address map.
module pte_trap_entry #(
	parameter logic [31:0] VECTOR_BASE = 32'h0000_0000,
	parameter bit FAULT_TOLERANCE_OPTION = 1'b1,
	parameter bit IMPRECISE_OPTION = 1'b0,
	parameter bit IRQ_EDGE_SELECT = 1'b0,
	parameter bit LOW_LATENCY = 1'b0,
	parameter bit DEBUG_OPTION = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [31:0] i_ex_pc,
	input wire logic [31:0] i_dec_pc,
	input wire logic i_in_delay_slot,
	input wire logic i_imm_prefixed,
	input wire logic [31:0] i_branch_target,
	input wire logic [31:0] i_fault_addr,
	input wire logic i_exc_ibus,
	input wire logic i_exc_illegal,
	input wire logic i_exc_dbus,
	input wire logic i_exc_ecc,
	input wire logic i_exc_unalign,
	input wire logic i_exc_div,
	input wire logic i_priv_instr,
	input wire logic i_ls_valid,
	input wire logic i_ls_base_r1,
	input wire logic [31:0] i_ls_addr,
	input wire logic i_itlb_miss,
	input wire logic i_dtlb_miss,
	input wire logic i_istore_viol,
	input wire logic i_dstore_viol,
	input wire logic i_fpu_valid,
	input wire logic i_fpu_is_div,
	input wire logic i_fpu_res_denorm,
	input wire logic i_fpu_res_nan,
	input wire logic i_fpu_a_zero,
	input wire logic i_fpu_b_inf,
	input wire logic i_fpu_snan,
	input wire logic i_fpu_bad_combo,
	input wire logic i_fpu_op_denorm,
	input wire logic i_break_request,
	input wire logic i_nonmaskable_break_request,
	input wire logic i_brki_exec,
	input wire logic [31:0] i_brki_target,
	input wire logic i_irq,
	input wire logic [31:0] i_irq_vec_addr,
	input wire logic i_return_from_interrupt,
	input wire logic i_return_from_break,
	input wire logic i_return_from_exception,
	output logic o_redirect,
	output logic [31:0] o_redirect_pc,
	output logic o_gpr_we,
	output logic [4:0] o_gpr_idx,
	output logic [31:0] o_gpr_data,
	output logic o_flush_younger,
	output logic o_reservation_clr,
	output logic o_core_fault_halt_out,
	output logic o_sw_bkpt,
	output logic [1:0] o_irq_ack,
	output logic [31:0] o_machine_status_reg
);
	pte_pkg::pte_regs_t r_ff;
	pte_pkg::pte_regs_t nxt_r;
	logic [4:0] fpu_flags;
	logic vm_on;
	logic stack_viol;
	logic exc_any;
	logic [4:0] exc_code;
	logic mmu_exc;
	logic ft_nested;
	logic brk_take;
	logic irq_req;
	logic irq_take;
	logic ecc_bus;

	// floating point flag classification of the current result
	always_comb
	begin
		fpu_flags = '0;
		fpu_flags[pte_pkg::FSR_DO] = i_fpu_valid & i_fpu_op_denorm;
		fpu_flags[pte_pkg::FSR_UF] = i_fpu_valid & i_fpu_res_denorm;
		fpu_flags[pte_pkg::FSR_OF] = i_fpu_valid & i_fpu_res_nan;
		fpu_flags[pte_pkg::FSR_DZ] = i_fpu_valid & i_fpu_is_div & i_fpu_a_zero & ~i_fpu_b_inf;
		fpu_flags[pte_pkg::FSR_IO] = i_fpu_valid & (i_fpu_snan | i_fpu_bad_combo);
	end

	// cause decode; tlb misses only count with translation switched on
	assign vm_on = r_ff.machine_status_reg[pte_pkg::MSR_VM];
	assign stack_viol = i_ls_valid & i_ls_base_r1 &
		((i_ls_addr < r_ff.stk_lo) | (i_ls_addr > r_ff.stk_hi));
	assign mmu_exc = (vm_on & (i_itlb_miss | i_dtlb_miss)) | i_istore_viol | i_dstore_viol;
	assign ecc_bus = i_exc_ecc & (i_exc_ibus | i_exc_dbus);

	// priority encoder, highest cause first
	always_comb
	begin
		exc_any = 1'b1;
		exc_code = '0;
		if (i_exc_ibus)
			exc_code = pte_pkg::EC_IBUS;
		else if (vm_on & i_itlb_miss)
			exc_code = pte_pkg::EC_ITLB;
		else if (i_istore_viol)
			exc_code = pte_pkg::EC_ISTORE;
		else if (i_exc_illegal)
			exc_code = pte_pkg::EC_ILLEGAL;
		else if (i_priv_instr & r_ff.machine_status_reg[pte_pkg::MSR_UM])
			exc_code = pte_pkg::EC_PRIV;
		else if (stack_viol)
			exc_code = pte_pkg::EC_STACK;
		else if (vm_on & i_dtlb_miss)
			exc_code = pte_pkg::EC_DTLB;
		else if (i_dstore_viol)
			exc_code = pte_pkg::EC_DSTORE;
		else if (i_exc_unalign)
			exc_code = pte_pkg::EC_UNALIGN;
		else if (i_exc_dbus)
			exc_code = pte_pkg::EC_DBUS;
		else if (i_exc_div)
			exc_code = pte_pkg::EC_DIV;
		else if (|fpu_flags)
			exc_code = pte_pkg::EC_FPU;
		else
			exc_any = 1'b0;
	end

	// a bus or opcode fault inside a running exception handler cannot be recovered
	assign ft_nested = FAULT_TOLERANCE_OPTION & (i_exc_ibus | i_exc_illegal | i_exc_dbus) &
		r_ff.machine_status_reg[pte_pkg::MSR_EIP] & ~r_ff.machine_status_reg[pte_pkg::MSR_EE];

	// break acceptance; the nonmaskable request ignores every status bit
	assign brk_take = i_nonmaskable_break_request |
		(i_break_request & ~r_ff.machine_status_reg[pte_pkg::MSR_BIP] & ~r_ff.machine_status_reg[pte_pkg::MSR_EIP]);

	// interrupt request: latched edge or the raw level
	assign irq_req = IRQ_EDGE_SELECT ? r_ff.irq_pend : i_irq;
	assign irq_take = irq_req & r_ff.machine_status_reg[pte_pkg::MSR_IE] &
		~r_ff.machine_status_reg[pte_pkg::MSR_BIP] & ~r_ff.machine_status_reg[pte_pkg::MSR_EIP];

	// next-state logic for the whole block
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.redir = 1'b0;
		nxt_r.gpr_we = 1'b0;
		nxt_r.resv_clr = 1'b0;
		nxt_r.flush = 1'b0;
		nxt_r.sw_bkpt = 1'b0;
		nxt_r.ack = pte_pkg::ACK_NONE;
		nxt_r.rdata = '0;
		// edge detector: previous sample against the present input
		nxt_r.irq_prev = i_irq;
		// register reads answer one cycle later, unmapped reads zero
		if (i_rd)
		begin
			case (i_addr)
				pte_pkg::OFF_MSR: nxt_r.rdata = r_ff.machine_status_reg;
				pte_pkg::OFF_ESR: nxt_r.rdata = r_ff.exception_status_reg;
				pte_pkg::OFF_EAR: nxt_r.rdata = r_ff.exception_address_reg;
				pte_pkg::OFF_FSR: nxt_r.rdata = r_ff.float_status_reg;
				pte_pkg::OFF_BTR: nxt_r.rdata = r_ff.branch_target_reg;
				pte_pkg::OFF_STK_LO: nxt_r.rdata = r_ff.stk_lo;
				pte_pkg::OFF_STK_HI: nxt_r.rdata = r_ff.stk_hi;
				default: nxt_r.rdata = '0;
			endcase
		end
		// software writes come first so that trap entry overrides them
		if (i_wr)
		begin
			case (i_addr)
				pte_pkg::OFF_MSR: nxt_r.machine_status_reg = i_wdata;
				pte_pkg::OFF_ESR: nxt_r.exception_status_reg = i_wdata;
				pte_pkg::OFF_EAR: nxt_r.exception_address_reg = i_wdata;
				pte_pkg::OFF_FSR: nxt_r.float_status_reg = i_wdata;
				pte_pkg::OFF_BTR: nxt_r.branch_target_reg = i_wdata;
				pte_pkg::OFF_STK_LO: nxt_r.stk_lo = i_wdata;
				pte_pkg::OFF_STK_HI: nxt_r.stk_hi = i_wdata;
				default: nxt_r.rdata = nxt_r.rdata;
			endcase
		end
		case (r_ff.state)
			pte_pkg::ST_RUN:
			begin
				// return instructions restore the saved mode bits
				if (i_return_from_interrupt)
					nxt_r.machine_status_reg[pte_pkg::MSR_IE] = 1'b1;
				if (i_return_from_break)
					nxt_r.machine_status_reg[pte_pkg::MSR_BIP] = 1'b0;
				if (i_return_from_exception)
				begin
					nxt_r.machine_status_reg[pte_pkg::MSR_EE] = 1'b1;
					nxt_r.machine_status_reg[pte_pkg::MSR_EIP] = 1'b0;
				end
				if (i_return_from_interrupt | i_return_from_break | i_return_from_exception)
				begin
					nxt_r.machine_status_reg[pte_pkg::MSR_UM] = r_ff.machine_status_reg[pte_pkg::MSR_UMS];
					nxt_r.machine_status_reg[pte_pkg::MSR_VM] = r_ff.machine_status_reg[pte_pkg::MSR_VMS];
				end
				if (DEBUG_OPTION & i_brki_exec & (i_brki_target == pte_pkg::VEC_BRK))
					nxt_r.sw_bkpt = 1'b1;
				if (ft_nested)
					nxt_r.state = pte_pkg::ST_HALT;
				else if (exc_any | brk_take | irq_take)
				begin
					// every entry saves and clears the mode bits
					nxt_r.machine_status_reg[pte_pkg::MSR_UMS] = r_ff.machine_status_reg[pte_pkg::MSR_UM];
					nxt_r.machine_status_reg[pte_pkg::MSR_VMS] = r_ff.machine_status_reg[pte_pkg::MSR_VM];
					nxt_r.machine_status_reg[pte_pkg::MSR_UM] = 1'b0;
					nxt_r.machine_status_reg[pte_pkg::MSR_VM] = 1'b0;
					nxt_r.resv_clr = 1'b1;
					nxt_r.redir = 1'b1;
					nxt_r.gpr_we = 1'b1;
					if (exc_any)
					begin
						// hardware exception; the execute-stage instruction dies
						nxt_r.redir_pc = VECTOR_BASE + pte_pkg::VEC_EXC;
						nxt_r.machine_status_reg[pte_pkg::MSR_EE] = 1'b0;
						nxt_r.machine_status_reg[pte_pkg::MSR_EIP] = 1'b1;
						nxt_r.exception_status_reg = {19'h0_0000, i_in_delay_slot, 7'h00, exc_code};
						nxt_r.exception_address_reg = i_fault_addr;
						nxt_r.float_status_reg = (exc_code == pte_pkg::EC_FPU) ?
							{27'h000_0000, fpu_flags} : r_ff.float_status_reg;
						// ecc bus faults may skip the flush to keep fmax up
						nxt_r.flush = ~(IMPRECISE_OPTION & ecc_bus);
						nxt_r.gpr_idx = pte_pkg::GPR_EXC;
						if (i_in_delay_slot)
						begin
							nxt_r.branch_target_reg = i_branch_target;
							nxt_r.gpr_data = i_imm_prefixed ? i_ex_pc - 32'h0000_0008 :
								i_ex_pc - 32'h0000_0004;
						end
						else if (mmu_exc)
							nxt_r.gpr_data = i_imm_prefixed ? i_ex_pc - 32'h0000_0004 :
								i_ex_pc;
						else
							nxt_r.gpr_data = i_ex_pc + 32'h0000_0004;
					end
					else if (brk_take)
					begin
						// execute stage completes, decode slot becomes the branch
						nxt_r.redir_pc = VECTOR_BASE + pte_pkg::VEC_BRK;
						nxt_r.gpr_idx = pte_pkg::GPR_BRK;
						nxt_r.gpr_data = i_dec_pc;
						nxt_r.machine_status_reg[pte_pkg::MSR_BIP] = 1'b1;
					end
					else
					begin
						nxt_r.redir_pc = LOW_LATENCY ? i_irq_vec_addr :
							VECTOR_BASE + pte_pkg::VEC_IRQ;
						nxt_r.gpr_idx = pte_pkg::GPR_IRQ;
						nxt_r.gpr_data = i_dec_pc;
						nxt_r.machine_status_reg[pte_pkg::MSR_IE] = 1'b0;
					end
				end
			end
			pte_pkg::ST_HALT:
				nxt_r.state = pte_pkg::ST_HALT; // only reset leaves the halt
			default:
				nxt_r.state = pte_pkg::ST_HALT;
		endcase
		// pending edge: a new edge wins over the clear by the taken interrupt
		if (r_ff.state == pte_pkg::ST_RUN && irq_take && !brk_take && !exc_any && !ft_nested)
			nxt_r.irq_pend = 1'b0;
		if (i_irq & ~r_ff.irq_prev)
			nxt_r.irq_pend = 1'b1;
		// acknowledge codes go to the controller only in low-latency mode
		if (LOW_LATENCY && r_ff.state == pte_pkg::ST_RUN)
		begin
			if (nxt_r.redir && nxt_r.gpr_idx == pte_pkg::GPR_IRQ)
				nxt_r.ack = pte_pkg::ACK_ENTRY;
			else if (i_return_from_interrupt)
				nxt_r.ack = pte_pkg::ACK_RETURN;
			else if (!r_ff.machine_status_reg[pte_pkg::MSR_IE] && nxt_r.machine_status_reg[pte_pkg::MSR_IE])
				nxt_r.ack = pte_pkg::ACK_REENABLE;
		end
	end

	// single state register; synchronous active-low reset
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			r_ff <= '0;
			r_ff.state <= pte_pkg::ST_RUN;
			r_ff.machine_status_reg <= pte_pkg::MSR_RESET;
		end
		else
			r_ff <= nxt_r;
	end

	assign o_rdata = r_ff.rdata;
	assign o_redirect = r_ff.redir;
	assign o_redirect_pc = r_ff.redir_pc;
	assign o_gpr_we = r_ff.gpr_we;
	assign o_gpr_idx = r_ff.gpr_idx;
	assign o_gpr_data = r_ff.gpr_data;
	assign o_flush_younger = r_ff.flush;
	assign o_reservation_clr = r_ff.resv_clr;
	assign o_core_fault_halt_out = (r_ff.state == pte_pkg::ST_HALT);
	assign o_sw_bkpt = r_ff.sw_bkpt;
	assign o_irq_ack = r_ff.ack;
	assign o_machine_status_reg = r_ff.machine_status_reg;

	// checks on the block's own behaviour
	property p_exc_vector;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(r_ff.state == pte_pkg::ST_RUN && exc_any && !ft_nested) |=>
			o_redirect && o_redirect_pc == VECTOR_BASE + pte_pkg::VEC_EXC &&
			o_machine_status_reg[pte_pkg::MSR_EIP] && !o_machine_status_reg[pte_pkg::MSR_EE];
	endproperty
	a_exc_vector: assert property (p_exc_vector)
		else $error("exception entry vector or status wrong");

	property p_halt;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(r_ff.state == pte_pkg::ST_RUN && ft_nested) |=> o_core_fault_halt_out [*3];
	endproperty
	a_halt: assert property (p_halt)
		else $error("nested fault did not halt");

	property p_brk_entry;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(r_ff.state == pte_pkg::ST_RUN && brk_take && !exc_any && !ft_nested) |=>
			o_gpr_idx == pte_pkg::GPR_BRK && o_gpr_data == $past(i_dec_pc) &&
			o_machine_status_reg[pte_pkg::MSR_BIP];
	endproperty
	a_brk_entry: assert property (p_brk_entry)
		else $error("break entry did not save decode pc");

	property p_mask_brk;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(r_ff.machine_status_reg[pte_pkg::MSR_BIP] && !i_nonmaskable_break_request && !exc_any && !irq_take)
			|=> !o_redirect;
	endproperty
	a_mask_brk: assert property (p_mask_brk)
		else $error("maskable break taken during break");

	property p_irq_block;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(r_ff.machine_status_reg[pte_pkg::MSR_EIP] || r_ff.machine_status_reg[pte_pkg::MSR_BIP]) |=>
			!(o_redirect && o_gpr_idx == pte_pkg::GPR_IRQ);
	endproperty
	a_irq_block: assert property (p_irq_block)
		else $error("interrupt taken while break or exception active");

	property p_irq_entry;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(o_redirect && o_gpr_idx == pte_pkg::GPR_IRQ) |->
			!o_machine_status_reg[pte_pkg::MSR_IE] && $past(r_ff.machine_status_reg[pte_pkg::MSR_IE]);
	endproperty
	a_irq_entry: assert property (p_irq_entry)
		else $error("interrupt entry without ie or ie left set");

	property p_ack_pulse;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(o_irq_ack != pte_pkg::ACK_NONE) |=> o_irq_ack != $past(o_irq_ack);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("acknowledge code held without cause");

	property p_edge_latch;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_irq && !r_ff.irq_prev) |=> r_ff.irq_pend;
	endproperty
	a_edge_latch: assert property (p_edge_latch)
		else $error("rising interrupt edge not latched");

	property p_mode_clear;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_redirect |-> o_reservation_clr && !o_machine_status_reg[pte_pkg::MSR_UM] &&
			o_machine_status_reg[pte_pkg::MSR_UMS] == $past(r_ff.machine_status_reg[pte_pkg::MSR_UM]);
	endproperty
	a_mode_clear: assert property (p_mode_clear)
		else $error("entry did not save and clear mode bits");
endmodule

//--- sim/pte_src_model.sv
module pte_src_model #(
	parameter logic [31:0] VECTOR_BASE = 32'h0000_0000
) (
	input wire logic i_core_clk,
	input wire logic i_redirect,
	input wire logic [31:0] i_redirect_pc,
	input wire logic [1:0] i_irq_ack,
	output logic o_irq,
	output logic [31:0] o_irq_vec_addr,
	output logic o_break_request,
	output logic o_nonmaskable_break_request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic go_irq = 1'b0, go_brk = 1'b0, go_nm = 1'b0, vec_pend = 1'b0;
	logic [31:0] go_vec = 32'h0000_0000;
	initial
	begin
		o_irq = 1'b0;
		o_irq_vec_addr = 32'h0000_0000;
		o_break_request = 1'b0;
		o_nonmaskable_break_request = 1'b0;
	end
	// commands are posted off the edge and launched on the next rising edge
	always @(posedge i_core_clk)
	begin
		o_irq <= go_irq; // single-cycle edge, low again before any new one
		o_nonmaskable_break_request <= go_nm; // one cycle per request
		go_irq <= 1'b0;
		go_nm <= 1'b0;
		go_brk <= 1'b0;
		if (go_irq)
			vec_pend <= 1'b1;
		else if (i_irq_ack == pte_pkg::ACK_ENTRY)
			vec_pend <= 1'b0;
		// handler address stands only while pending; otherwise it churns
		o_irq_vec_addr <= go_irq ? go_vec : (vec_pend ? o_irq_vec_addr : ~o_irq_vec_addr);
		// maskable break held until the core has branched to the break vector
		if (go_brk)
			o_break_request <= 1'b1;
		else if (i_redirect && i_redirect_pc == VECTOR_BASE + pte_pkg::VEC_BRK)
			o_break_request <= 1'b0;
	end
	task irq_pulse(input logic [31:0] a);
		go_vec = a;
		go_irq = 1'b1;
	endtask
	task brk_hold;
		go_brk = 1'b1;
	endtask
	task nm_pulse;
		go_nm = 1'b1;
	endtask
endmodule

//--- sim/pte_trap_entry_tb_top.sv
module pte_trap_entry_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] VB = 32'h0000_4000;
	localparam int IE = 1 << pte_pkg::MSR_IE;
	localparam int BREAK_IN_PROGRESS = 1 << pte_pkg::MSR_BIP;
	localparam int UMVM = (1 << pte_pkg::MSR_UM) | (1 << pte_pkg::MSR_VM);
	localparam int EXC = (1 << pte_pkg::MSR_EIP) | (1 << pte_pkg::MSR_UMS) | (1 << pte_pkg::MSR_VMS);
	logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000, i_ex_pc = 32'h0000_0000, i_dec_pc = 32'h0000_0000;
	logic [31:0] i_branch_target = 32'h0000_0000, i_fault_addr = 32'h0000_0000;
	logic [31:0] i_ls_addr = 32'h0000_3000, i_brki_target = 32'h0000_0018;
	logic i_in_delay_slot = 1'b0, i_imm_prefixed = 1'b0, i_exc_ibus = 1'b0, i_exc_illegal = 1'b0;
	logic i_exc_dbus = 1'b0, i_exc_ecc = 1'b0, i_exc_unalign = 1'b0, i_exc_div = 1'b0;
	logic i_priv_instr = 1'b0, i_ls_valid = 1'b0, i_ls_base_r1 = 1'b0, i_itlb_miss = 1'b0;
	logic i_dtlb_miss = 1'b0, i_istore_viol = 1'b0, i_dstore_viol = 1'b0, i_fpu_valid = 1'b0;
	logic i_fpu_is_div = 1'b0, i_fpu_res_denorm = 1'b0, i_fpu_res_nan = 1'b0, i_fpu_a_zero = 1'b0;
	logic i_fpu_b_inf = 1'b0, i_fpu_snan = 1'b0, i_fpu_bad_combo = 1'b0, i_fpu_op_denorm = 1'b0;
	logic i_brki_exec = 1'b0, i_return_from_interrupt = 1'b0, i_return_from_break = 1'b0;
	logic i_return_from_exception = 1'b0, i_irq, i_break_request, i_nonmaskable_break_request;
	logic [31:0] i_irq_vec_addr, o_rdata, o_redirect_pc, o_gpr_data, o_machine_status_reg;
	logic o_redirect, o_gpr_we, o_flush_younger, o_reservation_clr, o_core_fault_halt_out, o_sw_bkpt;
	logic [4:0] o_gpr_idx;
	logic [1:0] o_irq_ack;
	logic [31:0] seed = 32'heaa0_2c8c, dpc, pc, va, ra;
	int bad_count = 0, compares = 0;
	pte_trap_entry #(.VECTOR_BASE(VB), .FAULT_TOLERANCE_OPTION(1'b1), .IMPRECISE_OPTION(1'b0),
		.IRQ_EDGE_SELECT(1'b1), .LOW_LATENCY(1'b1), .DEBUG_OPTION(1'b1)) i_pte_trap_entry (
		.i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ex_pc, .i_dec_pc,
		.i_in_delay_slot, .i_imm_prefixed, .i_branch_target, .i_fault_addr, .i_exc_ibus,
		.i_exc_illegal, .i_exc_dbus, .i_exc_ecc, .i_exc_unalign, .i_exc_div, .i_priv_instr,
		.i_ls_valid, .i_ls_base_r1, .i_ls_addr, .i_itlb_miss, .i_dtlb_miss, .i_istore_viol,
		.i_dstore_viol, .i_fpu_valid, .i_fpu_is_div, .i_fpu_res_denorm, .i_fpu_res_nan,
		.i_fpu_a_zero, .i_fpu_b_inf, .i_fpu_snan, .i_fpu_bad_combo, .i_fpu_op_denorm,
		.i_break_request, .i_nonmaskable_break_request, .i_brki_exec, .i_brki_target, .i_irq,
		.i_irq_vec_addr, .i_return_from_interrupt, .i_return_from_break, .i_return_from_exception,
		.o_redirect, .o_redirect_pc, .o_gpr_we, .o_gpr_idx, .o_gpr_data, .o_flush_younger,
		.o_reservation_clr, .o_core_fault_halt_out, .o_sw_bkpt, .o_irq_ack, .o_machine_status_reg);
	pte_src_model #(.VECTOR_BASE(VB)) i_pte_src_model (.i_core_clk(i_core_clk),
		.i_redirect(o_redirect), .i_redirect_pc(o_redirect_pc), .i_irq_ack(o_irq_ack),
		.o_irq(i_irq), .o_irq_vec_addr(i_irq_vec_addr), .o_break_request(i_break_request),
		.o_nonmaskable_break_request(i_nonmaskable_break_request));
	// 250 MHz core clock
	always #2 i_core_clk = ~i_core_clk;
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed & 32'hFFFF_FFFC;
	endfunction
	task finish_test;
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// every task starts and ends just after an edge, so outputs are settled on return
	task reset_dut;
		@(posedge i_core_clk);
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask
	task newpc;
		@(posedge i_core_clk);
		dpc = rnd();
		pc = rnd();
		{i_dec_pc, i_ex_pc, i_branch_target, i_fault_addr} <= {dpc, pc, rnd(), rnd()};
		#1;
	endtask
	task idle(input int n);
		repeat (n)
		begin
			@(posedge i_core_clk);
			#1;
			chk(o_redirect, 1'b0);
		end
	endtask
	task wait_redir;
		for (int n = 0; n < 4 && o_redirect !== 1'b1; n++)
		begin
			@(posedge i_core_clk);
			#1;
		end
	endtask
	// one-cycle return or software break pulse: 0 irq, 1 break, 2 exception, 3 brki
	task pulse(input int k);
		@(posedge i_core_clk);
		{i_return_from_interrupt, i_return_from_break, i_return_from_exception, i_brki_exec}
			<= 4'b1000 >> k;
		@(posedge i_core_clk);
		{i_return_from_interrupt, i_return_from_break, i_return_from_exception, i_brki_exec}
			<= 4'b0000;
		#1;
	endtask
	task set_cause(input int k, input logic v);
		case (k)
			0: i_exc_ibus <= v;
			1: i_exc_illegal <= v;
			2: {i_exc_dbus, i_exc_ecc} <= {v, v};
			3: i_exc_unalign <= v;
			4: i_exc_div <= v;
			5: i_priv_instr <= v;
			6: {i_ls_valid, i_ls_base_r1} <= {v, v};
			7, 8: i_dtlb_miss <= v;
			9: i_itlb_miss <= v;
			10: i_istore_viol <= v;
			11: i_dstore_viol <= v;
			12: {i_fpu_valid, i_fpu_res_denorm} <= {v, v};
			13: {i_fpu_valid, i_fpu_res_nan} <= {v, v};
			14: {i_fpu_valid, i_fpu_is_div, i_fpu_a_zero} <= {v, v, v};
			default: {i_fpu_valid, i_fpu_snan} <= {v, v};
		endcase
		{i_in_delay_slot, i_imm_prefixed} <= {v & (k == 8), v & (k == 8)};
	endtask
	task trap(input int k);
		@(posedge i_core_clk);
		set_cause(k, 1'b1);
		@(posedge i_core_clk);
		set_cause(k, 1'b0);
		#1;
	endtask
	task chk_entry(input logic [31:0] tgt, input logic [4:0] idx, input logic [31:0] ret,
		input logic [31:0] machine_status_reg, input logic [1:0] ack);
		chk(o_redirect, 1'b1);
		chk(o_redirect_pc, tgt);
		chk(o_gpr_we, 1'b1);
		chk(o_gpr_idx, idx);
		chk(o_gpr_data, ret);
		chk(o_reservation_clr, 1'b1);
		chk(o_machine_status_reg, machine_status_reg);
		chk(o_irq_ack, ack);
	endtask
	// hang guard, far beyond the few hundred cycles the sequence needs
	initial
	begin
		#40000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		reset_dut();
		rd(pte_pkg::OFF_MSR, pte_pkg::MSR_RESET);
		rd(8'hF0, 32'h0000_0000);
		// edge latched while interrupts are off, served once enabled
		newpc();
		va = rnd();
		i_pte_src_model.irq_pulse(va);
		idle(4);
		wr(pte_pkg::OFF_MSR, IE);
		chk(o_irq_ack, pte_pkg::ACK_REENABLE);
		wait_redir();
		chk_entry(va, pte_pkg::GPR_IRQ, dpc, 0, pte_pkg::ACK_ENTRY);
		idle(1);
		chk(o_irq_ack, pte_pkg::ACK_NONE);
		pulse(0);
		chk(o_irq_ack, pte_pkg::ACK_RETURN);
		chk(o_machine_status_reg, IE);
		idle(1);
		chk(o_irq_ack, pte_pkg::ACK_NONE);
		// maskable break, then irq held pending and nonmaskable break taken while in break
		newpc();
		i_pte_src_model.brk_hold();
		wait_redir();
		chk_entry(VB + pte_pkg::VEC_BRK, pte_pkg::GPR_BRK, dpc, IE | BREAK_IN_PROGRESS, 2'h0);
		va = rnd();
		i_pte_src_model.irq_pulse(va);
		idle(4);
		newpc();
		i_pte_src_model.nm_pulse();
		wait_redir();
		chk_entry(VB + pte_pkg::VEC_BRK, pte_pkg::GPR_BRK, dpc, IE | BREAK_IN_PROGRESS, 2'h0);
		pulse(1);
		chk(o_machine_status_reg, IE);
		wait_redir();
		chk_entry(va, pte_pkg::GPR_IRQ, dpc, 0, pte_pkg::ACK_ENTRY);
		pulse(3);
		chk(o_sw_bkpt, 1'b1);
		// every cause from user and virtual mode; bus and opcode causes nest into a halt
		for (int k = 0; k < 16; k++)
		begin
			reset_dut();
			wr(pte_pkg::OFF_MSR, UMVM);
			wr(pte_pkg::OFF_STK_LO, 32'h0000_1000);
			wr(pte_pkg::OFF_STK_HI, 32'h0000_2000);
			newpc();
			trap(k);
			ra = (k == 8) ? pc - 32'h0000_0008 : ((k == 7 || (k > 8 && k < 12)) ? pc : pc + 32'h0000_0004);
			chk_entry(VB + pte_pkg::VEC_EXC, pte_pkg::GPR_EXC, ra, EXC, 2'h0);
			chk(o_flush_younger, 1'b1);
			rd(pte_pkg::OFF_EAR, i_fault_addr);
			// the float cause loads one flag into the float status register
			va = (k == 12) ? 1 << pte_pkg::FSR_UF : ((k == 13) ? 1 << pte_pkg::FSR_OF :
				((k == 14) ? 1 << pte_pkg::FSR_DZ : 1 << pte_pkg::FSR_IO));
			if (k > 11)
				rd(pte_pkg::OFF_FSR, va);
			if (k == 8)
			begin
				rd(pte_pkg::OFF_ESR, (1 << pte_pkg::ESR_DS) | pte_pkg::EC_DTLB);
				rd(pte_pkg::OFF_BTR, i_branch_target);
			end
			if (k < 3)
			begin
				trap(k);
				chk(o_core_fault_halt_out, 1'b1);
				chk(o_redirect, 1'b0);
			end
			if (k == 3)
				pulse(2);
		end
		finish_test();
	end
endmodule
